// ===== verilog/dsb_pkg.sv
// Package: constants, states and carriers of the two-word burst SRAM port
package dsb_pkg;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int DATA_W     = 8;      // Eight-bit variant word
    localparam int GRAN_W     = 4;      // Nibble write granularity
    localparam int ADDR_W     = 20;     // External address inputs
    localparam int BURST_LEN  = 2;      // Words per transaction
    localparam int BANK_CNT   = 2;      // Arrays holding the word pair
    localparam bit SEED_EN    = 1'b0;   // Eight-bit variant ignores the seed
    localparam int SEL_W      = DATA_W / GRAN_W;
    localparam int BUF_DEPTH  = 2;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [1:0] CNT_RST  = 2'h0;
    localparam logic       EDGE_RST = 1'h0;

    // ==========================================================
    // Burst sequencer states
    // ==========================================================
    typedef enum logic [4:0] {
        DSB_IDLE = 5'h01,
        DSB_RD1  = 5'h02,
        DSB_RD2  = 5'h04,
        DSB_WR1  = 5'h08,
        DSB_WR2  = 5'h10
    } dsb_state_t;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic                  load_n;
        logic                  read_not_write;
        logic [ADDR_W-1:0]     addr;
        logic                  seed;
        logic [SEL_W-1:0]      sel_n;
        logic [DATA_W-1:0]     data;
        logic                  single_clk;
    } dsb_pins_t;

    typedef struct packed {
        logic [ADDR_W-1:0]     row;
        logic                  seed;
    } dsb_cmd_t;

endpackage : dsb_pkg

// ===== verilog/dsb_burst_port.sv
// Module: command, address, write-select and data port of a two-word burst SRAM
//
// Behaviour
// - Strobe low starts cycle; address, direction latched
// - Every transaction moves exactly two words
// - Nibble selects sampled with their data word
// - Select zero bits 3..0, one bits 7..4
// - Deselected nibble ignored, stored nibble kept
// - One address bus serves reads and writes
// - Narrow variants: internal burst LSB starts zero
// - Wide variants: seed bit starts linear counter
// - Address ignored when port not selected
// - Direction high reads, low writes
// - Read words launched on output clock edges
// - Inputs captured, accesses begun on positive edge
// - Write word captured on positive edge only
// - Single-clock mode launches on input clock edges
// - Two arrays together hold each word pair
// - Data outputs released when no read selected
// - One write word per positive clock edge
`timescale 1ns/1ps

module dsb_burst_port #(
    parameter int DATA_W = dsb_pkg::DATA_W,
    parameter int GRAN_W = dsb_pkg::GRAN_W,
    parameter int ADDR_W = dsb_pkg::ADDR_W,
    parameter bit SEED_EN = dsb_pkg::SEED_EN
) (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    // Controller command pins
    input  wire logic                       cycle_load_strobe_n_in,
    input  wire logic                       read_not_write_in,
    input  wire logic [dsb_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                       burst_seed_bit_in,
    input  wire logic [dsb_pkg::SEL_W-1:0]  nibble_write_sel_n_in,
    input  wire logic                       single_clock_mode_in,
    // Data pins
    input  wire logic [dsb_pkg::DATA_W-1:0] dq_in,
    output logic      [dsb_pkg::DATA_W-1:0] dq_out,
    output logic                            dq_oe_out,
    output logic      [1:0]                 launch_edge_out,
    // Read stream handshake
    input  wire logic                       rd_ready_in,
    output logic                            rd_valid_out,
    output logic                            cmd_ready_out
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (DATA_W != dsb_pkg::DATA_W || ADDR_W != dsb_pkg::ADDR_W || GRAN_W != dsb_pkg::GRAN_W) begin : g_chk_geom
        $error("Geometry parameters must match the package carriers");
    end
    if (DATA_W % GRAN_W != 0) begin : g_chk_gran
        $error("Data width must be a whole number of write groups");
    end
    if (dsb_pkg::BURST_LEN != dsb_pkg::BANK_CNT) begin : g_chk_banks
        $error("Each word of a burst needs its own array");
    end
    if (dsb_pkg::BUF_DEPTH != dsb_pkg::BURST_LEN) begin : g_chk_buf
        $error("Read buffer must hold exactly one burst");
    end

    localparam int SEL_W = DATA_W / GRAN_W;
    localparam int ROWS  = 2 ** ADDR_W;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    dsb_pkg::dsb_pins_t pins_raw;
    dsb_pkg::dsb_pins_t sync1_q;
    dsb_pkg::dsb_pins_t sync2_q;

    assign pins_raw = '{load_n: cycle_load_strobe_n_in, read_not_write: read_not_write_in,
                        addr: addr_in, seed: burst_seed_bit_in, sel_n: nibble_write_sel_n_in,
                        data: dq_in, single_clk: single_clock_mode_in};

    // All ones out of reset: strobe reads high, so no load is taken
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // Burst sequencer
    // ==========================================================
    dsb_pkg::dsb_state_t state_q;
    dsb_pkg::dsb_state_t state_d;
    dsb_pkg::dsb_cmd_t   cmd_q;
    dsb_pkg::dsb_cmd_t   cmd_d;

    wire logic cmd_take;
    wire logic take_read;
    wire logic take_write;
    wire logic in_idle;
    wire logic buf_empty;

    assign in_idle    = (state_q == dsb_pkg::DSB_IDLE);
    // Loads wait for an empty buffer, so a burst always finds room
    assign cmd_ready_out = in_idle && buf_empty;
    assign cmd_take   = cmd_ready_out && !sync2_q.load_n;
    assign take_read  = cmd_take && sync2_q.read_not_write;
    assign take_write = cmd_take && !sync2_q.read_not_write;

    dsb_pkg::dsb_cmd_t   cmd_load;

    // Address is held only from a selected cycle
    assign cmd_load = '{row: sync2_q.addr, seed: sync2_q.seed};
    assign cmd_d    = cmd_take ? cmd_load : cmd_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            dsb_pkg::DSB_IDLE: begin
                if (take_read) begin
                    state_d = dsb_pkg::DSB_RD1;
                end else if (take_write) begin
                    state_d = dsb_pkg::DSB_WR1;
                end
            end
            dsb_pkg::DSB_RD1: state_d = dsb_pkg::DSB_RD2;
            dsb_pkg::DSB_RD2: state_d = dsb_pkg::DSB_IDLE;
            dsb_pkg::DSB_WR1: state_d = dsb_pkg::DSB_WR2;
            dsb_pkg::DSB_WR2: state_d = dsb_pkg::DSB_IDLE;
            default:          state_d = dsb_pkg::DSB_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= dsb_pkg::DSB_IDLE;
            cmd_q   <= '0;
        end else begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
        end
    end

    // ==========================================================
    // Burst counter and bank select
    // ==========================================================
    wire logic second_word;
    wire logic seed_bit;
    wire logic bank_sel;
    wire logic wr_active;
    wire logic rd_active;

    assign second_word = (state_q == dsb_pkg::DSB_RD2) || (state_q == dsb_pkg::DSB_WR2);
    assign seed_bit    = SEED_EN ? cmd_q.seed : 1'b0;
    assign bank_sel    = seed_bit ^ second_word;
    assign wr_active   = (state_q == dsb_pkg::DSB_WR1) || (state_q == dsb_pkg::DSB_WR2);
    assign rd_active   = (state_q == dsb_pkg::DSB_RD1) || (state_q == dsb_pkg::DSB_RD2);

    // ==========================================================
    // Storage: two arrays hold the even and odd word of a pair
    // ==========================================================
    logic [DATA_W-1:0] mem_q [dsb_pkg::BANK_CNT][ROWS];

    wire logic [DATA_W-1:0] old_word;
    wire logic [DATA_W-1:0] merged_word;

    assign old_word = mem_q[bank_sel][cmd_q.row];

    // Word in flight is the synchronised data with its own selects
    for (genvar g = 0; g < SEL_W; g++) begin : g_merge
        assign merged_word[g*GRAN_W +: GRAN_W] = sync2_q.sel_n[g]
            ? old_word[g*GRAN_W +: GRAN_W]
            : sync2_q.data[g*GRAN_W +: GRAN_W];
    end

    always_ff @(posedge clk_in) begin
        if (wr_active) begin
            mem_q[bank_sel][cmd_q.row] <= merged_word;
        end
    end

    // ==========================================================
    // Two-entry read buffer
    // ==========================================================
    logic [DATA_W-1:0] buf_q [dsb_pkg::BUF_DEPTH];
    logic              wr_ptr_q;
    logic              rd_ptr_q;
    logic [1:0]        cnt_q;
    logic [1:0]        cnt_d;
    logic              edge_q;

    wire logic buf_in_ready;
    wire logic push;
    wire logic pop;

    assign buf_empty    = (cnt_q == dsb_pkg::CNT_RST);
    assign buf_in_ready = (cnt_q < 2'(dsb_pkg::BUF_DEPTH));
    assign push         = rd_active && buf_in_ready;
    assign pop          = rd_valid_out && rd_ready_in;
    assign cnt_d        = cnt_q + 2'(push) - 2'(pop);

    always_ff @(posedge clk_in) begin
        if (push) begin
            buf_q[wr_ptr_q] <= old_word;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q    <= dsb_pkg::CNT_RST;
            edge_q   <= dsb_pkg::EDGE_RST;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            cnt_q    <= cnt_d;
            edge_q   <= edge_q ^ pop;
        end
    end

    // ==========================================================
    // Output pins
    // ==========================================================
    assign rd_valid_out    = !buf_empty;
    assign dq_oe_out       = !buf_empty;
    assign dq_out          = buf_q[rd_ptr_q];
    // Bit 1 high: output clock pair; bit 0 high: negative edge
    assign launch_edge_out = {!sync2_q.single_clk, edge_q};

    // ==========================================================
    // Check helpers: where the last write landed
    // ==========================================================
    logic              chk_bank_q;
    logic [ADDR_W-1:0] chk_row_q;

    wire logic [DATA_W-1:0] landed_word;

    always_ff @(posedge clk_in) begin
        chk_bank_q <= bank_sel;
        chk_row_q  <= cmd_q.row;
    end

    assign landed_word = mem_q[chk_bank_q][chk_row_q];

    // ==========================================================
    // Checks
    // ==========================================================
    a_load_starts_burst: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_take |=> !in_idle) else $error("Taken command did not leave idle");

    a_read_two_words: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take_read |=> push ##1 push ##1 !push) else $error("Read burst did not push two words");

    a_write_two_words: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take_write |=> wr_active [*2] ##1 !wr_active) else $error("Write burst not two words");

    a_direction_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take_read |=> state_q == dsb_pkg::DSB_RD1) else $error("Read direction not followed");

    a_addr_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !cmd_take |=> cmd_q == $past(cmd_q)) else $error("Address changed without a load");

    a_bank_order: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_active && !second_word |=> bank_sel != $past(bank_sel)) else $error("Burst bank did not advance");

    // Each write group either takes the pin nibble or keeps the stored one
    for (genvar g = 0; g < SEL_W; g++) begin : g_group_chk
        a_nibble_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
            wr_active && sync2_q.sel_n[g] |=>
            landed_word[g*GRAN_W +: GRAN_W] == $past(old_word[g*GRAN_W +: GRAN_W]))
            else $error("Deselected nibble altered");

        a_nibble_written: assert property (@(posedge clk_in) disable iff (!rst_n_in)
            wr_active && !sync2_q.sel_n[g] |=>
            landed_word[g*GRAN_W +: GRAN_W] == $past(sync2_q.data[g*GRAN_W +: GRAN_W]))
            else $error("Selected nibble not written");
    end

    a_oe_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        in_idle && buf_empty |=> !dq_oe_out) else $error("Data pins driven without a read");

    a_no_overflow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_active |-> buf_in_ready) else $error("Read word found no buffer room");

    a_take_loads: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_take |=> cmd_q.row == $past(sync2_q.addr))
        else $error("Taken address not held");

    a_refused_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !sync2_q.load_n && in_idle && !buf_empty |=> in_idle)
        else $error("Load taken with read data pending");

    a_write_dir: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        take_write |=> state_q == dsb_pkg::DSB_WR1)
        else $error("Write direction not followed");

    a_burst_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cmd_take |-> ##3 in_idle)
        else $error("Burst did not end after two words");

    a_write_banks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_active && !second_word |=> bank_sel != $past(bank_sel))
        else $error("Write bank did not advance");

    a_even_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !SEED_EN && (rd_active || wr_active) && !second_word |-> !bank_sel)
        else $error("Burst did not start at the even word");

    a_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_active |=> landed_word == $past(merged_word))
        else $error("Write word did not reach the array");

    a_push_bank: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        push |=> buf_q[$past(wr_ptr_q)] == $past(old_word))
        else $error("Buffered word not from the array");

    a_valid_stands: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(dq_out))
        else $error("Read word not held");

    a_launch_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        pop |=> launch_edge_out[0] != $past(launch_edge_out[0]))
        else $error("Launch edge did not alternate");

    a_mode_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> launch_edge_out[1] == !$past(sync1_q.single_clk))
        else $error("Launch pair not from mode pin");

    a_cnt_bounded: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cnt_q <= 2'(dsb_pkg::BUF_DEPTH))
        else $error("Read buffer count out of range");

    // ==========================================================
    // Coverage
    // ==========================================================
    c_read_burst: cover property (@(posedge clk_in) disable iff (!rst_n_in) take_read ##3 pop);
    c_write_burst: cover property (@(posedge clk_in) disable iff (!rst_n_in) take_write ##3 in_idle);
    c_stall_full: cover property (@(posedge clk_in) disable iff (!rst_n_in) !buf_in_ready && !rd_ready_in);
    c_refused: cover property (@(posedge clk_in) disable iff (!rst_n_in) !sync2_q.load_n && !cmd_ready_out);
    c_nibble_write: cover property (@(posedge clk_in) disable iff (!rst_n_in) wr_active && sync2_q.sel_n != '0);

endmodule : dsb_burst_port

// ===== test/dsb_ctrl_model.sv
// Memory controller model driving command, select and write data pins
`timescale 1ns/1ps

module dsb_ctrl_model (
    // Clock
    input  wire logic                       clk_in,
    // Command and data pins
    output logic                            load_n_out,
    output logic                            rnw_out,
    output logic      [dsb_pkg::ADDR_W-1:0] addr_out,
    output logic      [dsb_pkg::SEL_W-1:0]  sel_n_out,
    output logic      [dsb_pkg::DATA_W-1:0] dq_out
);
    initial begin
        load_n_out = 1'b1;
        rnw_out    = 1'b0;
        addr_out   = 20'h00000;
        sel_n_out  = 2'h3;
        dq_out     = 8'h00;
    end

    // One strobe cycle carries address and direction, then strobe rises and address, direction pins are driven inverted
    task automatic cmd(input logic [dsb_pkg::ADDR_W-1:0] a, input logic rd);
        @(posedge clk_in);
        load_n_out <= 1'b0;
        rnw_out    <= rd;
        addr_out   <= a;
        @(posedge clk_in);
        load_n_out <= 1'b1;
        rnw_out    <= ~rd;
        addr_out   <= ~a;
    endtask : cmd

    // Write words follow the command on the next two edges, first word first
    task automatic wr(input logic [dsb_pkg::ADDR_W-1:0] a, input logic [7:0] w0, input logic [7:0] w1,
                      input logic [1:0] s0, input logic [1:0] s1);
        cmd(a, 1'b0);
        dq_out    <= w0;
        sel_n_out <= s0;
        @(posedge clk_in);
        dq_out    <= w1;
        sel_n_out <= s1;
        @(posedge clk_in);
        dq_out    <= ~w1;
        sel_n_out <= ~s1;
    endtask : wr
endmodule : dsb_ctrl_model

// ===== test/tb.sv
// Testbench: random and corner bursts through the two-word burst SRAM port
`timescale 1ns/1ps

module tb;
    // ==========================================================
    // Signals
    // ==========================================================
    logic                       clk_in = 1'b0;
    logic                       rst_n_in = 1'b0;
    logic                       load_n, rnw, seed_bit = 1'b0, single_clk = 1'b0, rd_ready = 1'b0;
    logic [dsb_pkg::ADDR_W-1:0] addr;
    logic [dsb_pkg::SEL_W-1:0]  sel_n;
    logic [dsb_pkg::DATA_W-1:0] dq_w, dq_r;
    logic                       oe, rd_valid, cmd_ready;
    logic [1:0]                 launch;
    logic [7:0]                 mem [8];
    logic [19:0]                pool [4];
    integer                     seed = 32'hcff6e592;
    int                         n_fail = 0, n_compared = 0, cyc = 0;

    always #20 clk_in = ~clk_in;

    dsb_ctrl_model u_ctrl (.clk_in(clk_in), .load_n_out(load_n), .rnw_out(rnw), .addr_out(addr),
                           .sel_n_out(sel_n), .dq_out(dq_w));

    dsb_burst_port DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cycle_load_strobe_n_in(load_n),
        .read_not_write_in(rnw), .addr_in(addr), .burst_seed_bit_in(seed_bit),
        .nibble_write_sel_n_in(sel_n), .single_clock_mode_in(single_clk), .dq_in(dq_w), .dq_out(dq_r),
        .dq_oe_out(oe), .launch_edge_out(launch), .rd_ready_in(rd_ready), .rd_valid_out(rd_valid),
        .cmd_ready_out(cmd_ready));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] n, input logic [1:0] s_n);
        merge = {s_n[1] ? o[7:4] : n[7:4], s_n[0] ? o[3:0] : n[3:0]};
    endfunction : merge

    task automatic wait_ready();
        @(negedge clk_in);
        for (int i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge clk_in);
        check("cmd_ready", {7'h00, cmd_ready}, 8'h01);
        @(posedge clk_in);
        seed_bit   <= $random(seed);
        single_clk <= $random(seed);
    endtask : wait_ready

    task automatic wr_op(input int p, input logic [1:0] s0, input logic [1:0] s1);
        logic [7:0] w0, w1;
        w0 = $random(seed);
        w1 = $random(seed);
        wait_ready();
        mem[{p[1:0], 1'b0}] = merge(mem[{p[1:0], 1'b0}], w0, s0);
        mem[{p[1:0], 1'b1}] = merge(mem[{p[1:0], 1'b1}], w1, s1);
        u_ctrl.wr(pool[p], w0, w1, s0, s1);
    endtask : wr_op

    // Collects the burst with a randomly stalling receiver
    task automatic collect(input int p);
        int k;
        k = 0;
        for (int i = 0; i < 40 && k < 2; i++) begin
            @(posedge clk_in);
            rd_ready <= ($random(seed) % 3) != 0;
            @(negedge clk_in);
            if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
                check("dq_out", dq_r, mem[{p[1:0], k[0]}]);
                check("oe", {7'h00, oe}, 8'h01);
                check("launch", {6'h00, launch}, {6'h00, ~single_clk, k[0]});
                k++;
            end
        end
        check("words", k[7:0], 8'h02);
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        check("rd_valid", {7'h00, rd_valid}, 8'h00);
        check("oe_idle", {7'h00, oe}, 8'h00);
    endtask : collect

    task automatic rd_op(input int p);
        wait_ready();
        u_ctrl.cmd(pool[p], 1'b1);
        collect(p);
    endtask : rd_op

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 8000) begin
            n_fail++;
            results();
        end
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        pool = '{20'h00000, 20'hFFFFF, 20'h00000, 20'h00000};
        pool[2] = $random(seed);
        pool[3] = $random(seed);
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        check("oe_rst", {7'h00, oe}, 8'h00);
        check("ready_rst", {7'h00, cmd_ready}, 8'h01);
        $display("test reset done");
        foreach (pool[i]) wr_op(i, 2'h0, 2'h0);
        foreach (pool[i]) rd_op(i);
        $display("test full words done");
        for (int s = 0; s < 4; s++) begin
            wr_op(s, s[1:0], 2'(3 - s));
            rd_op(s);
        end
        $display("test nibble selects done");
        wait_ready();
        rd_ready <= 1'b0;
        u_ctrl.cmd(pool[1], 1'b1);
        for (int i = 0; i < 20 && rd_valid !== 1'b1; i++) @(negedge clk_in);
        u_ctrl.wr(pool[2], 8'h5A, 8'hA5, 2'h0, 2'h0);
        repeat (4) @(posedge clk_in);
        collect(1);
        rd_op(2);
        $display("test refused load done");
        for (int n = 0; n < 40; n++) begin
            if ($random(seed) % 2)
                wr_op(n % 4, 2'($random(seed)), 2'($random(seed)));
            else
                rd_op(n % 4);
        end
        $display("test random mix done");
        results();
    end
endmodule : tb
